// ==== dpd_cmd_decode.sv ====
// Command-interface decoder: deep power-down, clock change, NOP and CA bus decode.
// Assumes CA pins are presented as a rising/falling pair, synchronous to i_mclk,
// and a classic Wishbone master for status and control.
//
// Overview of operation
// - CKE low with CS# low, CA0/CA1 high, CA2 low enters deep power-down.
// - Entering deep power-down discards array contents; reads are undefined.
// - In deep power-down only CKE is observed; outputs are disabled.
// - After deep power-down exit the device waits for full reinitialization.
// - After clock change, commands accepted after two clocks plus exit latency.
// - NOP is CS# high, or CS# low with CA0-CA2 high.
// - NOP never aborts an operation already underway.
// - Illegal command or timing needs power-down and reinitialization.
// - Mode register write decode: address and operand over both edges.
// - Activate decode: row bits and bank over both edges.
// - Auto-precharge bit schedules precharge of the bank after the burst.
// - Column bit 0 is always zero.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps

module dpd_cmd_decode
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Memory command pins
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic [9:0] i_ca_r,
    input wire logic [9:0] i_ca_f,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_wb_err,
    // Decoded command to the core
    output logic o_cmd_valid,
    output logic [3:0] o_cmd_code,
    output logic [31:0] o_cmd_addr,
    output logic o_auto_pre,
    output logic o_outputs_en,
    output logic o_array_lost
);

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode
    function automatic dpd_cmd_pkg::cmd_fields_t decode(input dpd_cmd_pkg::ca_pins_t p,
                                                        input logic cke_prev);
        dpd_cmd_pkg::cmd_fields_t f;
        f = '0;
        f.cmd = dpd_cmd_pkg::CMD_ILLEGAL;
        if (!cke_prev && !p.cke)
        begin
            f.cmd = dpd_cmd_pkg::CMD_NOP;
        end
        else if (!cke_prev && p.cke)
        begin
            f.cmd = p.cs_n ? dpd_cmd_pkg::CMD_NOP : dpd_cmd_pkg::CMD_ILLEGAL;
        end
        else if (!p.cke)
        begin
            if (p.cs_n)
                f.cmd = dpd_cmd_pkg::CMD_PD;
            else if (p.ca_r[0] && p.ca_r[1] && !p.ca_r[2])
                f.cmd = dpd_cmd_pkg::CMD_DPD;
            else if (!p.ca_r[0] && !p.ca_r[1] && p.ca_r[2])
                f.cmd = dpd_cmd_pkg::CMD_SREF;
        end
        else if (p.cs_n || (p.ca_r[0] && p.ca_r[1] && p.ca_r[2]))
        begin
            f.cmd = dpd_cmd_pkg::CMD_NOP;
        end
        else if (!p.ca_r[0] && !p.ca_r[1])
        begin
            f.mr_addr = {p.ca_f[1:0], p.ca_r[9:4]};
            f.mr_op = p.ca_f[9:2];
            if (!p.ca_r[2])
                f.cmd = p.ca_r[3] ? dpd_cmd_pkg::CMD_MRR : dpd_cmd_pkg::CMD_MRW;
            else
                f.cmd = p.ca_r[3] ? dpd_cmd_pkg::CMD_REFAB : dpd_cmd_pkg::CMD_REFPB;
        end
        else if (!p.ca_r[0] && p.ca_r[1])
        begin
            f.cmd = dpd_cmd_pkg::CMD_ACT;
            f.row = {p.ca_f[9:8], p.ca_r[6:2], p.ca_f[7:0]};
            f.bank = p.ca_r[9:7];
        end
        else if (p.ca_r[0] && !p.ca_r[1])
        begin
            f.cmd = p.ca_r[2] ? dpd_cmd_pkg::CMD_RD : dpd_cmd_pkg::CMD_WR;
            f.bank = p.ca_r[9:7];
            f.col = {p.ca_f[9:1], p.ca_r[6:5], 1'b0};
            f.auto_pre = p.ca_f[0];
        end
        else if (!p.ca_r[2])
        begin
            f.cmd = p.ca_r[3] ? dpd_cmd_pkg::CMD_PRE : dpd_cmd_pkg::CMD_BST;
            f.all_banks = p.ca_r[4];
            f.bank = p.ca_r[9:7];
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Device state
    dpd_cmd_pkg::dev_state_t state_ff, nxt_state;
    logic cke_prev_ff, nxt_cke_prev;
    logic [3:0] settle_ff, nxt_settle;
    logic lost_ff, nxt_lost;
    logic clkchg_ff, nxt_clkchg;
    logic cmd_valid_ff, nxt_cmd_valid;
    logic [3:0] cmd_code_ff, nxt_cmd_code;
    logic [31:0] cmd_addr_ff, nxt_cmd_addr;
    logic auto_pre_ff, nxt_auto_pre;
    logic outen_ff, nxt_outen;
    logic [7:0] last_mr_ff, nxt_last_mr;
    dpd_cmd_pkg::cmd_fields_t dec;
    logic wb_hit;
    logic wr_ctrl;

    assign dec = decode({i_cke, i_cs_n, i_ca_r, i_ca_f}, cke_prev_ff);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cke_prev = i_cke;
        nxt_settle = settle_ff;
        nxt_lost = lost_ff;
        nxt_clkchg = clkchg_ff;
        nxt_cmd_valid = 1'b0;
        nxt_cmd_code = cmd_code_ff;
        nxt_cmd_addr = cmd_addr_ff;
        nxt_auto_pre = 1'b0;
        nxt_outen = 1'b0;
        nxt_last_mr = last_mr_ff;
        if (wr_ctrl && i_wb_dat[dpd_cmd_pkg::CTRL_CLKCHG_BIT])
            nxt_clkchg = 1'b1;
        case (state_ff)
            dpd_cmd_pkg::ST_NEED_INIT:
            begin
                // Core stays idle until software reports initialization done
                if (wr_ctrl && i_wb_dat[dpd_cmd_pkg::CTRL_INIT_DONE_BIT])
                begin
                    nxt_state = dpd_cmd_pkg::ST_ACTIVE;
                    nxt_clkchg = 1'b0;
                end
            end
            dpd_cmd_pkg::ST_ACTIVE:
            begin
                nxt_outen = 1'b1;
                // Illegal and deep power-down entry win over a pending clock change
                if (dec.cmd == dpd_cmd_pkg::CMD_ILLEGAL)
                begin
                    nxt_state = dpd_cmd_pkg::ST_ERROR;
                    nxt_outen = 1'b0;
                end
                else if (dec.cmd == dpd_cmd_pkg::CMD_DPD)
                begin
                    nxt_state = dpd_cmd_pkg::ST_DPD;
                    nxt_lost = 1'b1;
                    nxt_outen = 1'b0;
                end
                else if (clkchg_ff && !i_cke)
                begin
                    nxt_state = dpd_cmd_pkg::ST_SETTLE;
                    nxt_settle = dpd_cmd_pkg::READY_CNT;
                end
                else if (dec.cmd != dpd_cmd_pkg::CMD_NOP)
                begin
                    nxt_cmd_valid = 1'b1;
                    nxt_cmd_code = dec.cmd;
                    nxt_auto_pre = dec.auto_pre;
                    if (dec.cmd == dpd_cmd_pkg::CMD_MRW || dec.cmd == dpd_cmd_pkg::CMD_MRR)
                        nxt_cmd_addr = {16'h0000, dec.mr_addr, dec.mr_op};
                    else if (dec.cmd == dpd_cmd_pkg::CMD_ACT)
                        nxt_cmd_addr = {14'h0000, dec.bank, dec.row};
                    else
                        nxt_cmd_addr = {16'h0000, dec.all_banks, dec.bank, dec.col};
                    if (dec.cmd == dpd_cmd_pkg::CMD_WR || dec.cmd == dpd_cmd_pkg::CMD_ACT)
                        nxt_lost = 1'b0;
                    if (dec.cmd == dpd_cmd_pkg::CMD_MRW)
                        nxt_last_mr = dec.mr_addr;
                end
            end
            dpd_cmd_pkg::ST_DPD:
            begin
                // Only CKE is watched; everything else is a maintain NOP
                if (cke_prev_ff == 1'b0 && i_cke)
                    nxt_state = dpd_cmd_pkg::ST_NEED_INIT;
            end
            dpd_cmd_pkg::ST_SETTLE:
            begin
                // Count valid clocks with CKE high before accepting commands
                if (!i_cke)
                    nxt_settle = dpd_cmd_pkg::READY_CNT;
                else if (settle_ff == 4'h0)
                begin
                    nxt_state = dpd_cmd_pkg::ST_ACTIVE;
                    nxt_clkchg = 1'b0;
                end
                else
                    nxt_settle = settle_ff - 4'h1;
            end
            dpd_cmd_pkg::ST_ERROR:
            begin
                if (dec.cmd == dpd_cmd_pkg::CMD_PD || dec.cmd == dpd_cmd_pkg::CMD_DPD)
                    nxt_state = dpd_cmd_pkg::ST_NEED_INIT;
            end
            default:
            begin
                nxt_state = dpd_cmd_pkg::ST_NEED_INIT;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_ff <= dpd_cmd_pkg::ST_NEED_INIT;
            cke_prev_ff <= 1'b0;
            settle_ff <= 4'h0;
            lost_ff <= 1'b1;
            clkchg_ff <= 1'b0;
            cmd_valid_ff <= 1'b0;
            cmd_code_ff <= 4'h0;
            cmd_addr_ff <= 32'h0000_0000;
            auto_pre_ff <= 1'b0;
            outen_ff <= 1'b0;
            last_mr_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            cke_prev_ff <= nxt_cke_prev;
            settle_ff <= nxt_settle;
            lost_ff <= nxt_lost;
            clkchg_ff <= nxt_clkchg;
            cmd_valid_ff <= nxt_cmd_valid;
            cmd_code_ff <= nxt_cmd_code;
            cmd_addr_ff <= nxt_cmd_addr;
            auto_pre_ff <= nxt_auto_pre;
            outen_ff <= nxt_outen;
            last_mr_ff <= nxt_last_mr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack (err if unmapped) one cycle after the request, dropped the next cycle
    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [31:0] status_word;

    assign wb_hit = i_wb_cyc && i_wb_stb && !ack_ff && !err_ff;
    // Control write lands at the edge at which the master samples ack
    assign wr_ctrl = i_wb_cyc && i_wb_stb && ack_ff && i_wb_we && i_wb_sel[0]
        && (i_wb_adr == dpd_cmd_pkg::ADDR_CTRL);

    always_comb
    begin
        status_word = dpd_cmd_pkg::ZERO_WORD;
        status_word[dpd_cmd_pkg::STAT_DPD_BIT] = (state_ff == dpd_cmd_pkg::ST_DPD);
        status_word[dpd_cmd_pkg::STAT_ERR_BIT] = (state_ff == dpd_cmd_pkg::ST_ERROR);
        status_word[dpd_cmd_pkg::STAT_INIT_BIT] = (state_ff == dpd_cmd_pkg::ST_NEED_INIT);
        status_word[dpd_cmd_pkg::STAT_READY_BIT] = (state_ff == dpd_cmd_pkg::ST_ACTIVE);
        status_word[dpd_cmd_pkg::STAT_LOST_BIT] = lost_ff;
        status_word[dpd_cmd_pkg::STAT_SETTLE_BIT] = (state_ff == dpd_cmd_pkg::ST_SETTLE);
    end

    always_comb
    begin
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_rdat = rdat_ff;
        if (wb_hit)
        begin
            if (i_wb_adr == dpd_cmd_pkg::ADDR_CTRL)
            begin
                nxt_ack = 1'b1;
                nxt_rdat = {30'h0, (state_ff == dpd_cmd_pkg::ST_NEED_INIT), clkchg_ff};
            end
            else if (i_wb_adr == dpd_cmd_pkg::ADDR_STATUS)
            begin
                nxt_ack = 1'b1;
                nxt_rdat = status_word;
            end
            else if (i_wb_adr == dpd_cmd_pkg::ADDR_CMD)
            begin
                nxt_ack = 1'b1;
                nxt_rdat = {28'h000_0000, cmd_code_ff};
            end
            else if (i_wb_adr == dpd_cmd_pkg::ADDR_ROWCOL)
            begin
                nxt_ack = 1'b1;
                // Array contents are undefined after deep power-down
                nxt_rdat = lost_ff ? dpd_cmd_pkg::ERR_WORD : cmd_addr_ff;
            end
            else if (i_wb_adr == dpd_cmd_pkg::ADDR_MODE)
            begin
                nxt_ack = 1'b1;
                nxt_rdat = {24'h00_0000, last_mr_ff};
            end
            else
            begin
                nxt_err = 1'b1;
                nxt_rdat = dpd_cmd_pkg::ZERO_WORD;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            rdat_ff <= nxt_rdat;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_err = err_ff;
    assign o_wb_dat = rdat_ff;
    assign o_cmd_valid = cmd_valid_ff;
    assign o_cmd_code = cmd_code_ff;
    assign o_cmd_addr = cmd_addr_ff;
    assign o_auto_pre = auto_pre_ff;
    assign o_outputs_en = outen_ff;
    assign o_array_lost = lost_ff;

endmodule // dpd_cmd_decode

// ==== dpd_cmd_decode_props.sv ====
// Checker for the command decoder, watching its ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module dpd_cmd_decode_chk
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Command pins and bus request
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic [9:0] i_ca_r,
    input wire logic [9:0] i_ca_f,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    // Design outputs
    input wire logic o_wb_ack,
    input wire logic o_wb_err,
    input wire logic o_cmd_valid,
    input wire logic [3:0] o_cmd_code,
    input wire logic [31:0] o_cmd_addr,
    input wire logic o_auto_pre,
    input wire logic o_outputs_en,
    input wire logic o_array_lost
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // A selected command with CKE high on both edges while ready
    sequence s_live;
        i_cke && $past(i_cke) && !i_cs_n && o_outputs_en;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_NOP_CS: assert property (i_cke && $past(i_cke) && i_cs_n |=> !o_cmd_valid)
        else $error("command out while deselected");
    AST_NOP_CA: assert property (!i_cs_n && i_ca_r[2:0] == 3'h7 |=> !o_cmd_valid)
        else $error("command out on NOP code");
    AST_DPD_IN: assert property ($past(i_cke) && !i_cke && !i_cs_n
        && i_ca_r[2:0] == 3'h3 && o_outputs_en |=> !o_outputs_en && o_array_lost)
        else $error("deep power-down entry missed");
    AST_DPD_QUIET: assert property (!i_cke && $past(!i_cke) |=> !o_cmd_valid)
        else $error("command out with CKE low");
    AST_AP_PAIR: assert property (o_auto_pre |-> o_cmd_valid)
        else $error("auto precharge without command");
    AST_RDWR: assert property (s_live ##0 i_ca_r[1:0] == 2'h1 |=> o_cmd_valid
        && o_cmd_code == ($past(i_ca_r[2]) ? 4'h8 : 4'h7) && o_auto_pre == $past(i_ca_f[0])
        && o_cmd_addr == {17'h0, $past(i_ca_r[9:7]), $past(i_ca_f[9:1]), $past(i_ca_r[6:5]), 1'b0})
        else $error("read or write decode wrong");
    AST_ACT: assert property (s_live ##0 i_ca_r[1:0] == 2'h2 |=> o_cmd_valid
        && o_cmd_code == 4'h6 && !o_array_lost && o_cmd_addr == {14'h0, $past(i_ca_r[9:7]),
        $past(i_ca_f[9:8]), $past(i_ca_r[6:2]), $past(i_ca_f[7:0])})
        else $error("activate decode wrong");
    AST_MRW: assert property (s_live ##0 i_ca_r[3:0] == 4'h0 |=> o_cmd_valid
        && o_cmd_code == 4'h2
        && o_cmd_addr == {16'h0, $past(i_ca_f[1:0]), $past(i_ca_r[9:4]), $past(i_ca_f[9:2])})
        else $error("mode write decode wrong");
    AST_PRE: assert property (s_live ##0 i_ca_r[3:0] == 4'hB |=> o_cmd_valid
        && o_cmd_code == 4'h9 && o_cmd_addr[15:12] == {$past(i_ca_r[4]), $past(i_ca_r[9:7])})
        else $error("precharge decode wrong");
    AST_ACK: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err
        |=> (o_wb_ack || o_wb_err) ##1 !(o_wb_ack || o_wb_err))
        else $error("bus answer not a single next-cycle pulse");
    COV_AP: cover property (o_cmd_valid && o_auto_pre);
    COV_DPD: cover property (!o_outputs_en && o_array_lost && !i_cke);
    COV_ERR: cover property (o_wb_err);
endmodule // dpd_cmd_decode_chk

bind dpd_cmd_decode dpd_cmd_decode_chk i_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_cke(i_cke),
    .i_cs_n(i_cs_n), .i_ca_r(i_ca_r), .i_ca_f(i_ca_f), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
    .o_cmd_addr(o_cmd_addr), .o_auto_pre(o_auto_pre), .o_outputs_en(o_outputs_en),
    .o_array_lost(o_array_lost));

// ==== dpd_cmd_pkg.sv ====
// Package for the command decoder: encodings, field positions, state and carriers.
// Assumes a single 50 MHz clock domain and synchronous pin sampling.
package dpd_cmd_pkg;

    localparam int CLK_PERIOD_NS = 20;
    // Valid-clock periods needed after a clock change before commands are taken
    localparam int CLK_SETTLE_CYCLES = 2;
    // Power-down exit latency, in ns, and its cycle count (rounded up)
    localparam int EXIT_LAT_NS = 15;
    localparam int EXIT_LAT_CYCLES = (EXIT_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYCLES = CLK_SETTLE_CYCLES + EXIT_LAT_CYCLES;
    localparam logic [3:0] READY_CNT = 4'(READY_CYCLES);

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_ROWCOL = 8'h0C;
    localparam logic [7:0] ADDR_MODE = 8'h10;

    // Control register bits
    localparam int CTRL_CLKCHG_BIT = 0;
    localparam int CTRL_INIT_DONE_BIT = 1;
    localparam int CTRL_CLR_ERR_BIT = 2;

    // Status register bits
    localparam int STAT_DPD_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_INIT_BIT = 2;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_LOST_BIT = 4;
    localparam int STAT_SETTLE_BIT = 5;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] ERR_WORD = 32'hDEAD_0000;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_NOP, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT,
        CMD_WR, CMD_RD, CMD_PRE, CMD_BST, CMD_DPD, CMD_SREF, CMD_PD, CMD_ILLEGAL
    } cmd_t;

    typedef enum {
        ST_NEED_INIT, ST_ACTIVE, ST_DPD, ST_SETTLE, ST_ERROR
    } dev_state_t;

    // Command and address pins of one rising/falling pair
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [9:0] ca_r;
        logic [9:0] ca_f;
    } ca_pins_t;

    // Decoded fields of one command
    typedef struct packed {
        cmd_t cmd;
        logic [7:0] mr_addr;
        logic [7:0] mr_op;
        logic [14:0] row;
        logic [2:0] bank;
        logic [11:0] col;
        logic auto_pre;
        logic all_banks;
    } cmd_fields_t;

endpackage

// ==== dram_dpd_clockchg_cmd_decode_tb.sv ====
// Self-checking bench for the command decoder.
// Assumes the controller model drives the pins and Wishbone is driven here.
`timescale 1ns/100ps
module dram_dpd_clockchg_cmd_decode_tb;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_rdat, cmd_addr;
    logic wb_ack, wb_err, cmd_valid, auto_pre, outputs_en, array_lost;
    logic [3:0] cmd_code;
    dpd_cmd_pkg::ca_pins_t pins;
    logic [36:0] cmd_q[$];
    logic [32:0] wb_q[$];
    int error_cnt = 0, cmp_count = 0;
    always #10 i_mclk = ~i_mclk;
    mem_ctl_model i_ctl (.i_mclk(i_mclk), .o_pins(pins));
    dpd_cmd_decode i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cke(pins.cke), .i_cs_n(pins.cs_n),
        .i_ca_r(pins.ca_r), .i_ca_f(pins.ca_f), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_dat),
        .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_wb_err(wb_err), .o_cmd_valid(cmd_valid),
        .o_cmd_code(cmd_code), .o_cmd_addr(cmd_addr), .o_auto_pre(auto_pre),
        .o_outputs_en(outputs_en), .o_array_lost(array_lost));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [36:0] seen, input logic [36:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        error_cnt += cmd_q.size() + wb_q.size();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge i_mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 20);
        if (n == 20)
            error_cnt++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [32:0] exp);
        wb_q.push_back(exp);
        wb(1'b0, adr, 32'($urandom));
    endtask
    task automatic cmd(input logic [36:0] exp, input logic [9:0] r, input logic [9:0] f);
        if (exp != 37'h0)
            cmd_q.push_back(exp);
        i_ctl.send(1'b1, 1'b0, r, f);
    endtask
    always @(posedge i_mclk)
    begin
        if (!i_rst && cmd_valid !== 1'b0)
            check({cmd_code, cmd_addr, auto_pre}, cmd_q.size() ? cmd_q.pop_front() : 37'h0);
        if (!i_rst && (wb_ack | wb_err) !== 1'b0 && !wb_we)
            check(37'({wb_err, wb_rdat}), wb_q.size() ? 37'(wb_q.pop_front()) : 37'h0);
    end
    initial
    begin
        #80000;
        error_cnt++;
        final_report();
    end
    initial
    begin
        logic [2:0] ba;
        logic [14:0] row;
        logic [11:0] col;
        logic [7:0] ma, op;
        logic ap, rw;
        void'($urandom(87829));
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0014);
        rd(8'h40, 33'h1_0000_0000);
        cmd(37'h0, 10'h002, 10'h000);
        i_ctl.idle(1'b1, 1);
        wb(1'b1, dpd_cmd_pkg::ADDR_CTRL, 32'h0000_0002);
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0018);
        check({35'h0, outputs_en, array_lost}, 37'h3);
        repeat (8)
        begin
            {ba, row, col, ma, op, ap, rw} = 48'({$urandom, $urandom});
            cmd({4'h6, 14'h0, ba, row, 1'b0}, {ba, row[12:8], 2'h2},
                {row[14:13], row[7:0]});
            cmd({(rw ? 4'h8 : 4'h7), 17'h0, ba, col[11:1], 1'b0, ap},
                {ba, col[2:1], 2'h0, rw, 2'h1}, {col[11:3], ap});
            cmd({4'h2, 16'h0, ma, op, 1'b0}, {ma[5:0], 4'h0}, {op, ma[7:6]});
            cmd({4'h9, 16'h0, ap, ba, 13'h0}, {ba, 2'h0, ap, 4'hB}, 10'($urandom));
            cmd(37'h0, {7'($urandom), 3'h7}, 10'($urandom));
            i_ctl.idle(1'b1, 1);
        end
        i_ctl.send(1'b0, 1'b0, {7'($urandom), 3'h3}, 10'($urandom));
        i_ctl.idle(1'b0, 2);
        repeat (4) i_ctl.send(1'b0, 1'b0, 10'($urandom), 10'($urandom));
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0011);
        rd(dpd_cmd_pkg::ADDR_ROWCOL, {1'b0, dpd_cmd_pkg::ERR_WORD});
        check({35'h0, outputs_en, array_lost}, 37'h1);
        i_ctl.send(1'b1, 1'b1, 10'h3FF, 10'h3FF);
        i_ctl.idle(1'b1, 3);
        cmd(37'h0, 10'h002, 10'h000);
        i_ctl.idle(1'b1, 1);
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0014);
        wb(1'b1, dpd_cmd_pkg::ADDR_CTRL, 32'h0000_0002);
        cmd({4'h6, 33'h0}, 10'h002, 10'h000);
        i_ctl.idle(1'b1, 1);
        // Clock change with CKE low, then the settle count
        wb(1'b1, dpd_cmd_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(dpd_cmd_pkg::ADDR_CTRL, 33'h0_0000_0001);
        i_ctl.send(1'b0, 1'b1, 10'h3FF, 10'h3FF);
        i_ctl.idle(1'b0, 3);
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0020);
        i_ctl.send(1'b1, 1'b1, 10'h3FF, 10'h3FF);
        i_ctl.idle(1'b1, dpd_cmd_pkg::READY_CYCLES + 1);
        cmd({4'h6, 33'h0}, 10'h002, 10'h000);
        cmd({4'h2, 16'h0, 16'h021A, 1'b0}, 10'h020, 10'h068);
        i_ctl.idle(1'b1, 1);
        rd(dpd_cmd_pkg::ADDR_MODE, 33'h0_0000_0002);
        rd(dpd_cmd_pkg::ADDR_ROWCOL, 33'h0_0000_021A);
        rd(dpd_cmd_pkg::ADDR_CMD, 33'h0_0000_0002);
        // CKE rising with CS# low is illegal
        wb(1'b1, dpd_cmd_pkg::ADDR_CTRL, 32'h0000_0000);
        // Power-down entry is reported as a decoded command
        cmd_q.push_back({4'hD, 33'h0});
        i_ctl.send(1'b0, 1'b1, 10'h3FF, 10'h3FF);
        i_ctl.send(1'b1, 1'b0, 10'h002, 10'h000);
        i_ctl.idle(1'b1, 1);
        cmd(37'h0, 10'h002, 10'h000);
        i_ctl.idle(1'b1, 1);
        rd(dpd_cmd_pkg::ADDR_STATUS, 33'h0_0000_0002);
        repeat (3) @(posedge i_mclk);
        final_report();
    end
endmodule // dram_dpd_clockchg_cmd_decode_tb

// ==== mem_ctl_model.sv ====
// Memory controller model driving CKE, CS# and the CA rising/falling pair.
// Assumes the caller sequences commands; one command per rising edge.
`timescale 1ns/100ps
module mem_ctl_model
(
    // Clock
    input wire logic i_mclk,
    // Command pins
    output dpd_cmd_pkg::ca_pins_t o_pins
);
    // Clock is never stopped or retimed here
    initial o_pins = '{1'b1, 1'b1, 10'h3FF, 10'h3FF};
    // Caller keeps CS# high on CKE changes except DPD entry and the illegal CKE rise, and no MRW in flight at DPD entry
    task automatic send(input logic cke, input logic cs_n, input logic [9:0] r, input logic [9:0] f);
        @(posedge i_mclk);
        o_pins <= '{cke, cs_n, r, f};
    endtask
    // Deselected NOPs, CKE held; CA is don't-care so it churns
    task automatic idle(input logic cke, input int n);
        repeat (n) send(cke, 1'b1, 10'($urandom), 10'($urandom));
    endtask
endmodule // mem_ctl_model
